// ### logic/csrs_defines.svh
`ifndef CSRS_DEFINES_SVH
`define CSRS_DEFINES_SVH
// Overview of operation
// - Indirect port accesses go to the location held in the paired pointer.
// - First indirect port reaches bank 0 only; second reaches bank chosen by bank pointer.
// - Indirect port aimed at itself reads 00H and a write changes nothing.
// - Both memory pointers are real 8-bit read/write registers.
// - Bank pointer holds one bank bit at bit 0; bits 7 to 1 read zero.
// - Resets clear bank bit, except watchdog time-out reset during idle or sleep.
// - Direct addressing always reaches bank 0; other banks only indirectly.
// - Writing program counter low jumps within page and adds a dummy cycle.
// - Table read fetches word at table pointers; high byte into holding register.
// - Status writes change only arithmetic flags; time-out and power-down ignore data.
// - Carry set on add carry or subtract no-borrow; also rotate through carry.
// - Aux carry set on low nibble carry, or no nibble borrow in subtract.
// - Zero flag set when add, subtract or logic result is zero, cleared otherwise; rotates leave it unchanged.
// - Overflow set when carry into top bit differs from carry out.
// - Power-down flag cleared by power-up or clear watchdog, set by halt.
// - Time-out flag cleared by power-up, clear watchdog or halt; set by time-out.
// - Interrupts and calls never save the status register automatically.
// - No direct register-to-register move; data passes through the accumulator.
// - Reads of unused special addresses return zero.
// - Status bits: time-out 5, power-down 4, overflow 3, zero 2, aux 1, carry 0.
// - Table high byte is read-only and changes only when a table read completes or a reset clears it.
`define CSRS_ADDR_IND0      8'h00
`define CSRS_ADDR_PTR0      8'h01
`define CSRS_ADDR_IND1      8'h02
`define CSRS_ADDR_PTR1      8'h03
`define CSRS_ADDR_BANK      8'h04
`define CSRS_ADDR_ACCUM     8'h05
`define CSRS_ADDR_PC_LOW    8'h06
`define CSRS_ADDR_TPTR_LO   8'h07
`define CSRS_ADDR_TBL_HI    8'h08
`define CSRS_ADDR_TPTR_HI   8'h09
`define CSRS_ADDR_STATUS    8'h0A
`define CSRS_SFR_LAST       8'h7F
`define CSRS_BIT_WDTO       5
`define CSRS_BIT_PWRDN      4
`define CSRS_BIT_OVF        3
`define CSRS_BIT_Z          2
`define CSRS_BIT_AUXC       1
`define CSRS_BIT_C          0
`define CSRS_RST_BANK       1'h0
`define CSRS_RST_BYTE       8'h00
`endif

// ### logic/csrs_pkg.sv
package csrs_pkg;
    typedef enum logic [2:0] {
        CSRS_ALU_NONE,
        CSRS_ALU_ADD,
        CSRS_ALU_SUB,
        CSRS_ALU_LOGIC,
        CSRS_ALU_RLC,
        CSRS_ALU_RRC
    } csrs_alu_op_t;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csrs_access_t;
    typedef struct packed {
        logic       req;
        logic [8:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } csrs_mem_req_t;
    typedef struct packed {
        logic wdto;
        logic pwrdn;
        logic ovf;
        logic z;
        logic auxc;
        logic c;
    } csrs_flags_t;
endpackage

// ### logic/csrs_addr_map.sv
`timescale 1ns/1ps
`include "csrs_defines.svh"
module csrs_addr_map (
    input  wire logic [7:0] cpu_addr,
    input  wire logic       bank_bit,
    input  wire logic [7:0] ptr0,
    input  wire logic [7:0] ptr1,
    output logic      [8:0] eff_addr,
    output logic            self_ref
);
    wire is_ind0 = (cpu_addr == `CSRS_ADDR_IND0);
    wire is_ind1 = (cpu_addr == `CSRS_ADDR_IND1);
    wire [8:0] ind0_addr = {1'b0, ptr0};
    wire [8:0] ind1_addr = {bank_bit, ptr1};
    wire [8:0] dir_addr = {1'b0, cpu_addr};
    assign eff_addr = is_ind0 ? ind0_addr : (is_ind1 ? ind1_addr : dir_addr);
    assign self_ref = (is_ind0 || is_ind1) && (eff_addr[8] == 1'b0)
                      && ((eff_addr[7:0] == `CSRS_ADDR_IND0)
                      || (eff_addr[7:0] == `CSRS_ADDR_IND1));
endmodule // csrs_addr_map

// ### logic/csrs_alu_flags.sv
`timescale 1ns/1ps
module csrs_alu_flags (
    input  wire csrs_pkg::csrs_alu_op_t op,
    input  wire logic [7:0]             a,
    input  wire logic [7:0]             b,
    input  wire logic                   c_in,
    output logic      [7:0]             result,
    output logic                        c_out,
    output logic                        ac_out,
    output logic                        ov_out
);
    wire [7:0] b_eff = (op == csrs_pkg::CSRS_ALU_SUB) ? ~b : b;
    wire cin_eff = (op == csrs_pkg::CSRS_ALU_SUB);
    wire [4:0] low_sum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
    wire [7:0] low7_sum = {1'b0, a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin_eff};
    wire [8:0] sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin_eff};
    wire arith = (op == csrs_pkg::CSRS_ALU_ADD) || (op == csrs_pkg::CSRS_ALU_SUB);
    wire rl = (op == csrs_pkg::CSRS_ALU_RLC);
    wire rr = (op == csrs_pkg::CSRS_ALU_RRC);
    assign result = arith ? sum[7:0] : (rl ? {a[6:0], c_in} : (rr ? {c_in, a[7:1]} : a));
    assign c_out = arith ? sum[8] : (rl ? a[7] : (rr ? a[0] : c_in));
    assign ac_out = low_sum[4];
    assign ov_out = low7_sum[7] ^ sum[8];
endmodule // csrs_alu_flags

// ### logic/core_special_register_set.sv
`timescale 1ns/1ps
`include "csrs_defines.svh"
module core_special_register_set (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   clk_en,
    input  wire logic                   power_up,
    input  wire logic                   wdt_reset_in_idle,
    input  wire csrs_pkg::csrs_access_t cpu_acc,
    input  wire csrs_pkg::csrs_alu_op_t alu_op,
    input  wire logic [7:0]             alu_operand,
    input  wire logic                   alu_to_mem,
    input  wire logic                   logic_op_z,
    input  wire logic                   clear_watchdog_instruction,
    input  wire logic                   halt_instruction,
    input  wire logic                   wdt_timeout,
    input  wire logic                   table_read,
    input  wire logic [15:0]            table_word,
    input  wire logic [7:0]             mem_rdata,
    input  wire logic [7:0]             pc_high_in,
    output logic      [7:0]             cpu_rdata,
    output csrs_pkg::csrs_mem_req_t     mem_req,
    output logic      [15:0]            pc_jump_addr,
    output logic                        pc_jump,
    output logic                        dummy_cycle,
    output logic      [15:0]            table_addr,
    output logic      [7:0]             table_low_dest,
    output logic                        table_low_valid,
    output logic      [7:0]             accumulator_reg
);
    // ****************************************
    // State
    // ****************************************
    logic [7:0] memory_pointer_first;
    logic [7:0] memory_pointer_second;
    logic       bank_select_bit;
    logic [7:0] program_counter_low;
    logic [7:0] table_pointer_low;
    logic [7:0] table_pointer_high;
    logic [7:0] table_high_byte;
    csrs_pkg::csrs_flags_t flags;
    logic       mem_rd_pend;

    // ****************************************
    // Decode
    // ****************************************
    logic [8:0] eff_addr;
    logic       self_ref;
    csrs_addr_map u_map (
        .cpu_addr (cpu_acc.addr),
        .bank_bit (bank_select_bit),
        .ptr0     (memory_pointer_first),
        .ptr1     (memory_pointer_second),
        .eff_addr (eff_addr),
        .self_ref (self_ref)
    );
    wire       is_sfr = (eff_addr[8] == 1'b0) && (eff_addr[7:0] <= `CSRS_SFR_LAST);
    wire       acc_ok = (cpu_acc.wr || cpu_acc.rd) && !self_ref;
    wire       wr_ok = cpu_acc.wr && !self_ref;
    wire [7:0] ea = eff_addr[7:0];
    wire       wr_ptr0 = wr_ok && is_sfr && (ea == `CSRS_ADDR_PTR0);
    wire       wr_ptr1 = wr_ok && is_sfr && (ea == `CSRS_ADDR_PTR1);
    wire       wr_bank = wr_ok && is_sfr && (ea == `CSRS_ADDR_BANK);
    wire       wr_accum = wr_ok && is_sfr && (ea == `CSRS_ADDR_ACCUM);
    wire       wr_pc_low = wr_ok && is_sfr && (ea == `CSRS_ADDR_PC_LOW);
    wire       wr_tptr_lo = wr_ok && is_sfr && (ea == `CSRS_ADDR_TPTR_LO);
    wire       wr_tptr_hi = wr_ok && is_sfr && (ea == `CSRS_ADDR_TPTR_HI);
    wire       wr_stat = wr_ok && is_sfr && (ea == `CSRS_ADDR_STATUS);

    // ****************************************
    // ALU and flags
    // ****************************************
    logic [7:0] alu_result;
    logic       alu_c;
    logic       alu_ac;
    logic       alu_ov;
    csrs_alu_flags u_alu (
        .op     (alu_op),
        .a      (accumulator_reg),
        .b      (alu_operand),
        .c_in   (flags.c),
        .result (alu_result),
        .c_out  (alu_c),
        .ac_out (alu_ac),
        .ov_out (alu_ov)
    );
    wire alu_arith = (alu_op == csrs_pkg::CSRS_ALU_ADD) || (alu_op == csrs_pkg::CSRS_ALU_SUB);
    wire alu_rot = (alu_op == csrs_pkg::CSRS_ALU_RLC) || (alu_op == csrs_pkg::CSRS_ALU_RRC);
    wire alu_any = (alu_op != csrs_pkg::CSRS_ALU_NONE);
    wire alu_zset = alu_arith || (alu_op == csrs_pkg::CSRS_ALU_LOGIC);
    wire alu_zero = (alu_op == csrs_pkg::CSRS_ALU_LOGIC) ? logic_op_z : (alu_result == 8'h00);

    csrs_pkg::csrs_flags_t next_flags;
    always_comb begin
        next_flags = flags;
        if (wr_stat) begin
            next_flags.ovf = cpu_acc.wdata[`CSRS_BIT_OVF];
            next_flags.z = cpu_acc.wdata[`CSRS_BIT_Z];
            next_flags.auxc = cpu_acc.wdata[`CSRS_BIT_AUXC];
            next_flags.c = cpu_acc.wdata[`CSRS_BIT_C];
        end
        if (alu_arith) begin
            next_flags.c = alu_c;
            next_flags.auxc = alu_ac;
            next_flags.ovf = alu_ov;
        end
        if (alu_rot) begin
            next_flags.c = alu_c;
        end
        if (alu_zset) begin
            next_flags.z = alu_zero;
        end
        if (clear_watchdog_instruction) begin
            next_flags.pwrdn = 1'b0;
            next_flags.wdto = 1'b0;
        end
        if (halt_instruction) begin
            next_flags.pwrdn = 1'b1;
            next_flags.wdto = 1'b0;
        end
        if (wdt_timeout) begin
            next_flags.wdto = 1'b1;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    wire [7:0] status_rd = {2'b00, flags.wdto, flags.pwrdn, flags.ovf,
                            flags.z, flags.auxc, flags.c};
    logic [7:0] sfr_rd;
    always_comb begin
        unique case (ea)
            `CSRS_ADDR_PTR0:    sfr_rd = memory_pointer_first;
            `CSRS_ADDR_PTR1:    sfr_rd = memory_pointer_second;
            `CSRS_ADDR_BANK:    sfr_rd = {7'h00, bank_select_bit};
            `CSRS_ADDR_ACCUM:   sfr_rd = accumulator_reg;
            `CSRS_ADDR_PC_LOW:  sfr_rd = program_counter_low;
            `CSRS_ADDR_TPTR_LO: sfr_rd = table_pointer_low;
            `CSRS_ADDR_TBL_HI:  sfr_rd = table_high_byte;
            `CSRS_ADDR_TPTR_HI: sfr_rd = table_pointer_high;
            `CSRS_ADDR_STATUS: sfr_rd = status_rd;
            default:           sfr_rd = 8'h00;
        endcase
    end
    wire [7:0] next_rdata = (acc_ok && is_sfr) ? sfr_rd : 8'h00;
    // RAM data is taken in the same cycle as the registered request
    wire [7:0] rdata_sel = mem_rd_pend ? mem_rdata : next_rdata;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            if (!wdt_reset_in_idle) begin
                bank_select_bit <= `CSRS_RST_BANK;
            end
            if (power_up) begin
                flags.wdto <= 1'b0;
                flags.pwrdn <= 1'b0;
            end
            flags.ovf <= 1'b0;
            flags.z <= 1'b0;
            flags.auxc <= 1'b0;
            flags.c <= 1'b0;
            memory_pointer_first <= `CSRS_RST_BYTE;
            memory_pointer_second <= `CSRS_RST_BYTE;
            accumulator_reg <= `CSRS_RST_BYTE;
            program_counter_low <= `CSRS_RST_BYTE;
            table_pointer_low <= `CSRS_RST_BYTE;
            table_pointer_high <= `CSRS_RST_BYTE;
            table_high_byte <= `CSRS_RST_BYTE;
        end else if (clk_en) begin
            flags <= next_flags;
            if (wr_ptr0) memory_pointer_first <= cpu_acc.wdata;
            if (wr_ptr1) memory_pointer_second <= cpu_acc.wdata;
            if (wr_bank) bank_select_bit <= cpu_acc.wdata[0];
            if (wr_pc_low) program_counter_low <= cpu_acc.wdata;
            if (wr_tptr_lo) table_pointer_low <= cpu_acc.wdata;
            if (wr_tptr_hi) table_pointer_high <= cpu_acc.wdata;
            if (table_read) table_high_byte <= table_word[15:8];
            if (alu_any && !alu_to_mem) begin
                accumulator_reg <= alu_result;
            end else if (wr_accum) begin
                accumulator_reg <= cpu_acc.wdata;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            cpu_rdata <= 8'h00;
            mem_rd_pend <= 1'b0;
            mem_req <= '0;
            pc_jump <= 1'b0;
            dummy_cycle <= 1'b0;
            pc_jump_addr <= 16'h0000;
            table_addr <= 16'h0000;
            table_low_dest <= 8'h00;
            table_low_valid <= 1'b0;
        end else if (clk_en) begin
            cpu_rdata <= rdata_sel;
            mem_rd_pend <= acc_ok && cpu_acc.rd && !is_sfr;
            mem_req.req <= acc_ok && !is_sfr;
            mem_req.addr <= eff_addr;
            mem_req.wr <= wr_ok && !is_sfr;
            mem_req.wdata <= cpu_acc.wdata;
            pc_jump <= wr_pc_low;
            dummy_cycle <= wr_pc_low;
            pc_jump_addr <= {pc_high_in, cpu_acc.wdata};
            table_addr <= {table_pointer_high, table_pointer_low};
            table_low_dest <= table_word[7:0];
            table_low_valid <= table_read;
        end
    end
endmodule // core_special_register_set

// ### tb/csrs_checker_assertions.sv
`timescale 1ns/1ps
// ************************************************************
// Port checker
// ************************************************************
module csrs_checker (
    input wire logic                    mclk,
    input wire logic                    rst,
    input wire logic                    clk_en,
    input wire csrs_pkg::csrs_access_t  cpu_acc,
    input wire logic                    alu_to_mem,
    input wire logic                    table_read,
    input wire logic [15:0]             table_word,
    input wire logic [7:0]              pc_high_in,
    input wire logic [7:0]              cpu_rdata,
    input wire csrs_pkg::csrs_mem_req_t mem_req,
    input wire logic [15:0]             pc_jump_addr,
    input wire logic                    pc_jump,
    input wire logic                    dummy_cycle,
    input wire logic [7:0]              table_low_dest,
    input wire logic                    table_low_valid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire pcl_wr = clk_en && cpu_acc.wr && cpu_acc.addr == 8'h06;
    wire drct   = clk_en && (cpu_acc.rd || cpu_acc.wr) && cpu_acc.addr[7];
    wire unused = clk_en && cpu_acc.rd && cpu_acc.addr > 8'h0A && !cpu_acc.addr[7];
    chk_pcl_jump: assert property (pcl_wr |=> pc_jump && dummy_cycle &&
        pc_jump_addr == {$past(pc_high_in), $past(cpu_acc.wdata)}) else $error("bad jump");
    chk_jump_cause: assert property (pc_jump |-> $past(pcl_wr))
        else $error("stray jump");
    chk_table_low: assert property (clk_en && table_read |=> table_low_valid &&
        table_low_dest == $past(table_word[7:0])) else $error("bad table low");
    chk_low_cause: assert property (table_low_valid |-> $past(table_read))
        else $error("stray table low");
    chk_direct_bank: assert property (drct |=> mem_req.req &&
        mem_req.addr == {1'b0, $past(cpu_acc.addr)}) else $error("direct not bank 0");
    chk_port0_bank: assert property (clk_en && cpu_acc.wr && cpu_acc.addr == 8'h00
        |=> !(mem_req.req && mem_req.addr[8])) else $error("first port left bank 0");
    chk_mem_wdata: assert property (clk_en && cpu_acc.wr && !alu_to_mem
        |=> !mem_req.wr || mem_req.wdata == $past(cpu_acc.wdata)) else $error("bad wdata");
    chk_unused_zero: assert property (unused |=> cpu_rdata == 8'h00)
        else $error("unused not zero");
    cov_jump: cover property (pcl_wr);
    cov_table: cover property (table_read);
    cov_direct: cover property (drct);
endmodule // csrs_checker

// ### tb/csrs_ram_model.sv
`timescale 1ns/1ps
// ************************************************************
// Data RAM behind the block
// ************************************************************
module csrs_ram_model (
    input  wire logic                    mclk,
    input  wire csrs_pkg::csrs_mem_req_t mem_req,
    output logic [7:0]                   mem_rdata
);
    logic [7:0] mem [0:511];
    initial for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'hA5;
    always @(posedge mclk) if (mem_req.req && mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    assign mem_rdata = mem[mem_req.addr];
endmodule // csrs_ram_model

// ### tb/core_special_register_set_bench.sv
`timescale 1ns/1ps
// ************************************************************
// Bench
// ************************************************************
module core_special_register_set_bench;
    logic mclk = 0, rst = 1, clk_en = 1, power_up = 1, wdt_reset_in_idle = 0;
    logic alu_to_mem = 0, logic_op_z = 0, clr_wd = 0, halt = 0, wdt_to = 0, table_read = 0;
    csrs_pkg::csrs_access_t  cpu_acc = '0;
    csrs_pkg::csrs_alu_op_t  alu_op = csrs_pkg::CSRS_ALU_NONE;
    csrs_pkg::csrs_mem_req_t mem_req;
    logic [7:0]  alu_operand = 8'h00, pc_high_in = 8'h12, mem_rdata, cpu_rdata;
    logic [7:0]  table_low_dest, accumulator_reg;
    logic [15:0] table_word = 16'h0000, pc_jump_addr, table_addr;
    logic        pc_jump, dummy_cycle, table_low_valid;
    int          bad_count = 0, n_tests = 0;
    logic [39:0] rows [6] = '{{8'h7F, 8'h01, 8'h80, 8'h0A, 5'h0, csrs_pkg::CSRS_ALU_ADD},
                              {8'hFF, 8'h01, 8'h00, 8'h07, 5'h0, csrs_pkg::CSRS_ALU_ADD},
                              {8'h80, 8'h01, 8'h7F, 8'h09, 5'h0, csrs_pkg::CSRS_ALU_SUB},
                              {8'h02, 8'h00, 8'h81, 8'h08, 5'h0, csrs_pkg::CSRS_ALU_RRC},
                              {8'h80, 8'h00, 8'h00, 8'h09, 5'h0, csrs_pkg::CSRS_ALU_RLC},
                              {8'h5A, 8'h00, 8'h5A, 8'h0D, 5'h1, csrs_pkg::CSRS_ALU_LOGIC}};
    always #5 mclk = ~mclk;
    core_special_register_set i_dut (.mclk(mclk), .rst(rst), .clk_en(clk_en),
        .power_up(power_up), .wdt_reset_in_idle(wdt_reset_in_idle), .cpu_acc(cpu_acc),
        .alu_op(alu_op), .alu_operand(alu_operand), .alu_to_mem(alu_to_mem),
        .logic_op_z(logic_op_z), .clear_watchdog_instruction(clr_wd),
        .halt_instruction(halt), .wdt_timeout(wdt_to), .table_read(table_read),
        .table_word(table_word), .mem_rdata(mem_rdata), .pc_high_in(pc_high_in),
        .cpu_rdata(cpu_rdata), .mem_req(mem_req), .pc_jump_addr(pc_jump_addr),
        .pc_jump(pc_jump), .dummy_cycle(dummy_cycle), .table_addr(table_addr),
        .table_low_dest(table_low_dest), .table_low_valid(table_low_valid),
        .accumulator_reg(accumulator_reg));
    csrs_ram_model i_ram (.mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
    task automatic chk(input logic [15:0] got, exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic bus(input logic r, w, input logic [7:0] a, d);
        @(posedge mclk);
        cpu_acc <= '{rd: r, wr: w, addr: a, wdata: d};
        @(posedge mclk);
        cpu_acc <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        bus(1, 0, a, 8'h00);
        chk({8'h00, cpu_rdata}, {8'h00, exp}, "read");
    endtask
    task automatic pulse(input int k);
        @(posedge mclk);
        {wdt_to, halt, clr_wd, table_read} <= 4'h1 << k;
        @(posedge mclk);
        {wdt_to, halt, clr_wd, table_read} <= 4'h0;
        #1;
    endtask
    task automatic do_reset(input logic pu, idle);
        @(posedge mclk);
        {rst, power_up, wdt_reset_in_idle} <= {1'b1, pu, idle};
        @(posedge mclk);
        {rst, power_up, wdt_reset_in_idle} <= 3'b000;
    endtask
    task automatic t_regs;
        rd(8'h04, 8'h00);
        rd(8'h0A, 8'h00);
        rd(8'h20, 8'h00);
        rd(8'h7F, 8'h00);
        rd(8'h00, 8'h00);
        bus(0, 1, 8'h01, 8'h5A);
        rd(8'h01, 8'h5A);
        bus(0, 1, 8'h03, 8'hC3);
        rd(8'h03, 8'hC3);
        $display("test regs done");
    endtask
    task automatic t_bank;
        bus(0, 1, 8'h04, 8'hFF);
        rd(8'h04, 8'h01);
        bus(0, 1, 8'h03, 8'h90);
        bus(0, 1, 8'h02, 8'h77);
        chk({6'h0, mem_req.req, mem_req.addr}, 16'h0390, "port1 addr");
        chk({8'h0, mem_req.wdata}, 16'h0077, "port1 data");
        bus(0, 1, 8'h01, 8'h90);
        bus(0, 1, 8'h00, 8'h66);
        chk({6'h0, mem_req.req, mem_req.addr}, 16'h0290, "port0 addr");
        bus(0, 1, 8'h85, 8'h11);
        chk({6'h0, mem_req.req, mem_req.addr}, 16'h0285, "direct addr");
        bus(1, 0, 8'h02, 8'h00);
        @(posedge mclk) #1;
        chk({8'h0, cpu_rdata}, 16'h0077, "port1 read");
        bus(1, 0, 8'h85, 8'h00);
        @(posedge mclk) #1;
        chk({8'h0, cpu_rdata}, 16'h0011, "direct read");
        do_reset(0, 1);
        rd(8'h04, 8'h01);
        do_reset(0, 0);
        rd(8'h04, 8'h00);
        $display("test bank done");
    endtask
    task automatic t_status;
        bus(0, 1, 8'h0A, 8'hFF);
        rd(8'h0A, 8'h0F);
        pulse(3);
        rd(8'h0A, 8'h2F);
        bus(0, 1, 8'h0A, 8'h00);
        rd(8'h0A, 8'h20);
        pulse(2);
        rd(8'h0A, 8'h10);
        pulse(1);
        rd(8'h0A, 8'h00);
        pulse(3);
        do_reset(0, 0);
        rd(8'h0A, 8'h20);
        do_reset(1, 0);
        rd(8'h0A, 8'h00);
        $display("test status done");
    endtask
    task automatic t_alu;
        foreach (rows[i]) begin
            bus(0, 1, 8'h05, rows[i][39:32]);
            @(posedge mclk);
            alu_op <= csrs_pkg::csrs_alu_op_t'(rows[i][2:0]);
            alu_operand <= rows[i][31:24];
            logic_op_z <= rows[i][3];
            @(posedge mclk);
            alu_op <= csrs_pkg::CSRS_ALU_NONE;
            logic_op_z <= 1'b0;
            #1;
            chk({8'h0, accumulator_reg}, {8'h0, rows[i][23:16]}, "alu result");
            rd(8'h0A, rows[i][15:8]);
        end
        $display("test alu done");
    endtask
    task automatic t_pcl_table;
        bus(0, 1, 8'h06, 8'h34);
        chk(pc_jump_addr, 16'h1234, "jump addr");
        chk({14'h0, pc_jump, dummy_cycle}, 16'h0003, "jump pulse");
        bus(0, 1, 8'h07, 8'h06);
        bus(0, 1, 8'h09, 8'h07);
        @(posedge mclk) table_word <= 16'h0F1A;
        #1;
        chk(table_addr, 16'h0706, "table addr");
        pulse(0);
        chk({7'h0, table_low_valid, table_low_dest}, 16'h011A, "table low");
        rd(8'h08, 8'h0F);
        bus(0, 1, 8'h08, 8'h55);
        rd(8'h08, 8'h0F);
        $display("test pcl table done");
    endtask
    task automatic t_freeze;
        @(posedge mclk) clk_en <= 1'b0;
        bus(0, 1, 8'h01, 8'h3C);
        @(posedge mclk) clk_en <= 1'b1;
        rd(8'h01, 8'h00);
        $display("test freeze done");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #20us;
        bad_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        conclude();
    end
    initial begin
        repeat (12) @(posedge mclk);
        {rst, power_up} <= 2'b00;
        t_regs();
        t_bank();
        t_status();
        t_alu();
        t_pcl_table();
        t_freeze();
        conclude();
    end
endmodule // core_special_register_set_bench
bind core_special_register_set csrs_checker i_chk (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .cpu_acc(cpu_acc), .alu_to_mem(alu_to_mem), .table_read(table_read),
    .table_word(table_word), .pc_high_in(pc_high_in), .cpu_rdata(cpu_rdata),
    .mem_req(mem_req), .pc_jump_addr(pc_jump_addr), .pc_jump(pc_jump),
    .dummy_cycle(dummy_cycle), .table_low_dest(table_low_dest),
    .table_low_valid(table_low_valid));
